// ### src/pdsc_pkg.sv
// package: register map, field layout and timing for the domain controller
package pdsc_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int POR_TIME_NS = 1000;
    localparam int POR_CYCLES =
        (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MOD_TIME_NS = 200;
    localparam int MOD_CYCLES =
        (MOD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] GO_CMD_OFS = 12'h120;
    localparam logic [11:0] TRANS_STAT_OFS = 12'h128;
    localparam logic [11:0] DOM_STAT_BASE = 12'h200;
    localparam logic [11:0] DOM_CTRL_BASE = 12'h300;
    localparam logic [11:0] MOD_STAT_BASE = 12'h800;
    localparam logic [11:0] MOD_CTRL_BASE = 12'hA00;

    // domain status fields
    localparam int DS_EMU_BIT = 11;
    localparam int DS_POWER_ON_RESET_COMPLETE_BIT = 9;
    localparam int DS_POR_BIT = 8;
    localparam int DS_STATE_LSB = 0;
    localparam int DS_STATE_W = 5;
    // domain control fields
    localparam int DC_IE_BIT = 9;
    localparam int DC_PGOOD_BIT = 8;
    localparam int DC_NEXT_BIT = 0;
    // module status fields
    localparam int MS_EMU_BIT = 17;
    localparam int MS_EMULATION_ALTERED_RESET_FLAG_BIT = 16;
    localparam int MS_CLK_BIT = 12;
    localparam int MS_MODRSTDN_BIT = 11;
    localparam int MS_MODRST_BIT = 10;
    localparam int MS_LOCRSTDN_BIT = 9;
    localparam int MS_LOCRST_BIT = 8;
    localparam int MS_STATE_W = 6;
    // module control fields
    localparam int MC_STATE_IE_BIT = 10;
    localparam int MC_RST_IE_BIT = 9;
    localparam int MC_LOCAL_BIT = 8;
    localparam int MC_NEXT_W = 3;

    // module state codes; codes 4h and above mean a transition
    localparam logic [5:0] MST_SWRST_DIS = 6'h00;
    localparam logic [5:0] MST_SYNC_RST = 6'h01;
    localparam logic [5:0] MST_DISABLE = 6'h02;
    localparam logic [5:0] MST_ENABLE = 6'h03;
    localparam logic [5:0] MST_TRANS = 6'h04;

    // reset values
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [5:0] MOD_STATE_RESET = 6'h00;
    localparam logic [2:0] MOD_NEXT_RESET = 3'h0;

    typedef enum logic [1:0] {DS_IDLE, DS_WAIT_PWR, DS_POR} pdsc_dom_e;
endpackage

// ### src/pdsc_domain_seq.sv
// file: power-up / power-down sequencer for one power domain
`timescale 1ns/1ps
module pdsc_domain_seq import pdsc_pkg::*; #(
    parameter logic BOOT_ON = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic next_on,
    input wire logic power_good,
    output logic on,
    output logic por_n,
    output logic por_done,
    output logic busy
);
    localparam logic [7:0] POR_LOAD = 8'(POR_CYCLES - 1);

    pdsc_dom_e state_q;
    logic [7:0] cnt_q;

    assign busy = (state_q != DS_IDLE);

    // sequence: wait for external power, hold power-on reset, release it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DS_IDLE;
            cnt_q <= 8'h00;
            on <= BOOT_ON;
            por_n <= BOOT_ON;
            por_done <= BOOT_ON;
        end else begin
            case (state_q)
                DS_IDLE: begin
                    if (start && next_on && !on) begin
                        por_n <= 1'b0;
                        por_done <= 1'b0;
                        cnt_q <= POR_LOAD;
                        // software reports power good before the domain is on
                        state_q <= power_good ? DS_POR : DS_WAIT_PWR;
                        on <= power_good;
                    end else if (start && !next_on && on) begin
                        // power-down: domain reset asserted at once
                        on <= 1'b0;
                        por_n <= 1'b0;
                        por_done <= 1'b0;
                    end
                end
                DS_WAIT_PWR: begin
                    if (power_good) begin
                        on <= 1'b1;
                        state_q <= DS_POR;
                    end
                end
                DS_POR: begin
                    if (cnt_q == 8'h00) begin
                        por_n <= 1'b1;
                        por_done <= 1'b1;
                        state_q <= DS_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: state_q <= DS_IDLE;
            endcase
        end
    end
endmodule

// ### src/pdsc_top.sv
// file: power domain / module status and control block with APB slave
// Functional notes
// - domain status bit 11 flags emulation change
// - domain status bit 9 shows reset done
// - domain status bit 8 mirrors power-on reset
// - domain status bits 4-0 give off/on state
// - domain control bit 9 enables emulation interrupt
// - domain control bit 0 holds target state
// - module status register fixed field layout
// - go compares next with current, transitions mismatches
// - module state codes 0-3, 4h+ transition
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module pdsc_top import pdsc_pkg::*; #(
    parameter int ND = 2,
    parameter int NM = 4,
    parameter logic [ND-1:0] BOOT_ON = 2'b01
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ND-1:0] emu_domain_evt,
    input wire logic [NM-1:0] emu_module_evt,
    input wire logic [NM-1:0] emu_mod_reset_evt,
    output logic [ND-1:0] emu_domain_irq,
    output logic [ND-1:0] domain_power_on,
    output logic [ND-1:0] domain_por_n,
    output logic [NM-1:0] module_clock_on,
    output logic [NM-1:0] module_reset_n,
    output logic [NM-1:0] local_reset_n
);
    localparam logic [7:0] MOD_LOAD = 8'(MOD_CYCLES - 1);

    // modules are spread over the domains round-robin
    function automatic int dom_of(input int m);
        return m % ND;
    endfunction

    // register index for a word within a bank, or -1 when outside
    function automatic int bank_idx(input logic [11:0] a,
                                    input logic [11:0] base, input int n);
        int i;
        i = -1;
        for (int k = 0; k < n; k++) begin
            if (a == base + 12'(4 * k)) begin
                i = k;
            end
        end
        return i;
    endfunction

    // domain control and state
    logic [ND-1:0] next_on_q, pgood_q, dom_ie_q, dom_emu_q, dom_emu_d;
    logic [ND-1:0] go_q, dom_on, dom_por_n, dom_por_done, dom_busy;
    // module control and state
    logic [5:0] mst_q [NM];
    logic [2:0] mnext_q [NM];
    logic [7:0] mcnt_q [NM];
    logic [NM-1:0] mie_q, mrie_q, mlocal_q, memu_q, memurst_q;

    // apb decode: access cycle while pready is high
    logic acc, wr;
    int dsi, dci, msi, mci;
    logic mapped;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign dsi = bank_idx(paddr, DOM_STAT_BASE, ND);
    assign dci = bank_idx(paddr, DOM_CTRL_BASE, ND);
    assign msi = bank_idx(paddr, MOD_STAT_BASE, NM);
    assign mci = bank_idx(paddr, MOD_CTRL_BASE, NM);
    assign mapped = (paddr == GO_CMD_OFS) || (paddr == TRANS_STAT_OFS) ||
        (dsi >= 0) || (dci >= 0) || (msi >= 0) || (mci >= 0);

    // one wait-free access cycle: pready rises the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // read data views
    function automatic logic [31:0] dom_stat(input int d);
        logic [31:0] v;
        v = RDATA_RESET;
        v[DS_EMU_BIT] = dom_emu_q[d];
        v[DS_POWER_ON_RESET_COMPLETE_BIT] = dom_por_done[d];
        v[DS_POR_BIT] = dom_por_n[d];
        v[DS_STATE_LSB +: DS_STATE_W] = 5'(dom_on[d]);
        return v;
    endfunction

    function automatic logic [31:0] mod_stat(input int m);
        logic [31:0] v;
        logic rel;
        v = RDATA_RESET;
        rel = module_reset_n[m];
        v[MS_EMU_BIT] = memu_q[m];
        v[MS_EMULATION_ALTERED_RESET_FLAG_BIT] = memurst_q[m];
        v[MS_CLK_BIT] = module_clock_on[m];
        v[MS_MODRSTDN_BIT] = rel;
        v[MS_MODRST_BIT] = rel;
        v[MS_LOCRSTDN_BIT] = local_reset_n[m];
        v[MS_LOCRST_BIT] = local_reset_n[m];
        v[MS_STATE_W-1:0] = mst_q[m];
        return v;
    endfunction

    // read data is captured in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RDATA_RESET;
        end else if (psel && !penable && !pwrite) begin
            prdata <= RDATA_RESET;
            if (paddr == TRANS_STAT_OFS) begin
                for (int d = 0; d < ND; d++) begin
                    prdata[d] <= dom_busy[d] || go_q[d];
                    for (int m = 0; m < NM; m++) begin
                        if (dom_of(m) == d && mst_q[m] >= MST_TRANS) begin
                            prdata[d] <= 1'b1;
                        end
                    end
                end
            end else if (dsi >= 0) begin
                prdata <= dom_stat(dsi);
            end else if (dci >= 0) begin
                prdata[DC_IE_BIT] <= dom_ie_q[dci];
                prdata[DC_PGOOD_BIT] <= pgood_q[dci];
                prdata[DC_NEXT_BIT] <= next_on_q[dci];
            end else if (msi >= 0) begin
                prdata <= mod_stat(msi);
            end else if (mci >= 0) begin
                prdata[MC_STATE_IE_BIT] <= mie_q[mci];
                prdata[MC_RST_IE_BIT] <= mrie_q[mci];
                prdata[MC_LOCAL_BIT] <= mlocal_q[mci];
                prdata[MC_NEXT_W-1:0] <= mnext_q[mci];
            end
        end
    end

    // domain control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_on_q <= BOOT_ON;
            pgood_q <= BOOT_ON;
            dom_ie_q <= '0;
        end else if (wr && dci >= 0) begin
            next_on_q[dci] <= pwdata[DC_NEXT_BIT];
            pgood_q[dci] <= pwdata[DC_PGOOD_BIT];
            dom_ie_q[dci] <= pwdata[DC_IE_BIT];
        end
    end

    // go command: a one-cycle pulse per domain, writes of 0 do nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= '0;
        end else if (wr && paddr == GO_CMD_OFS) begin
            go_q <= pwdata[ND-1:0];
        end else begin
            go_q <= '0;
        end
    end

    // emulation flag: a go on the domain clears it, a new event wins
    always_comb begin
        for (int d = 0; d < ND; d++) begin
            dom_emu_d[d] = emu_domain_evt[d] || (dom_emu_q[d] && !go_q[d]);
        end
    end

    // flag and interrupt; the output follows the same next values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dom_emu_q <= '0;
            emu_domain_irq <= '0;
        end else begin
            dom_emu_q <= dom_emu_d;
            for (int d = 0; d < ND; d++) begin
                emu_domain_irq[d] <= dom_emu_d[d] &&
                ((wr && dci == d) ? pwdata[DC_IE_BIT] : dom_ie_q[d]);
            end
        end
    end

    // one sequencer per domain
    for (genvar g = 0; g < ND; g++) begin : g_dom
        pdsc_domain_seq #(.BOOT_ON(BOOT_ON[g])) u_seq (
            .clk(pclk),
            .rst_n(presetn),
            .start(go_q[g] && (next_on_q[g] != dom_on[g])),
            .next_on(next_on_q[g]),
            .power_good(pgood_q[g]),
            .on(dom_on[g]),
            .por_n(dom_por_n[g]),
            .por_done(dom_por_done[g]),
            .busy(dom_busy[g])
        );
    end

    // domain pins mirror the sequencer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            domain_power_on <= '0;
            domain_por_n <= '0;
        end else begin
            domain_power_on <= dom_on;
            domain_por_n <= dom_por_n;
        end
    end

    // module control writes; next is accepted only as codes 0-3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mie_q <= '0;
            mrie_q <= '0;
            mlocal_q <= '0;
            for (int m = 0; m < NM; m++) begin
                mnext_q[m] <= MOD_NEXT_RESET;
            end
        end else if (wr && mci >= 0) begin
            mie_q[mci] <= pwdata[MC_STATE_IE_BIT];
            mrie_q[mci] <= pwdata[MC_RST_IE_BIT];
            mlocal_q[mci] <= pwdata[MC_LOCAL_BIT];
            mnext_q[mci] <= {1'b0, pwdata[1:0]};
        end
    end

    // module state: a mismatch at go shows 4h+next until the move ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int m = 0; m < NM; m++) begin
                mst_q[m] <= MOD_STATE_RESET;
                mcnt_q[m] <= 8'h00;
            end
        end else begin
            for (int m = 0; m < NM; m++) begin
                if (mst_q[m] >= MST_TRANS) begin
                    if (mcnt_q[m] == 8'h00) begin
                        mst_q[m] <= mst_q[m] - MST_TRANS;
                    end else begin
                        mcnt_q[m] <= mcnt_q[m] - 8'h01;
                    end
                end else if (go_q[dom_of(m)] &&
                             mst_q[m] != {3'b000, mnext_q[m]}) begin
                    mst_q[m] <= MST_TRANS + {3'b000, mnext_q[m]};
                    mcnt_q[m] <= MOD_LOAD;
                end
            end
        end
    end

    // module pins and emulation flags; a go on the domain clears flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_clock_on <= '0;
            module_reset_n <= '0;
            local_reset_n <= '0;
            memu_q <= '0;
            memurst_q <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                module_clock_on[m] <= (mst_q[m] == MST_ENABLE) ||
                    (mst_q[m] == MST_SYNC_RST);
                module_reset_n[m] <= (mst_q[m] == MST_ENABLE) ||
                    (mst_q[m] == MST_DISABLE);
                local_reset_n[m] <= mlocal_q[m];
                memu_q[m] <= emu_module_evt[m] ||
                    (memu_q[m] && !go_q[dom_of(m)]);
                memurst_q[m] <= emu_mod_reset_evt[m] ||
                    (memurst_q[m] && !go_q[dom_of(m)]);
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence dstat_read_s;
        psel && !penable && !pwrite && paddr == DOM_STAT_BASE;
    endsequence
    sequence mstat_read_s;
        psel && !penable && !pwrite && paddr == MOD_STAT_BASE;
    endsequence
    sequence go_dom0_s;
        wr && paddr == GO_CMD_OFS && pwdata[0];
    endsequence

    emu_set_a: assert property (emu_domain_evt[0] |=> dom_emu_q[0])
        else $error("emulation flag not set after event");
    por_done_a: assert property (dom_por_done[0] |-> dom_por_n[0])
        else $error("reset done while reset still asserted");
    por_off_a: assert property (!dom_on[1] |-> !dom_por_n[1])
        else $error("domain off but reset released");
    state_rd_a: assert property (dstat_read_s ##1 1'b1 |->
        prdata[4:0] == 5'($past(dom_on[0])) && prdata[DS_EMU_BIT] ==
        $past(dom_emu_q[0]))
        else $error("domain status read value wrong");
    ie_wr_a: assert property (wr && dci == 1 |=>
        dom_ie_q[1] == $past(pwdata[DC_IE_BIT]))
        else $error("interrupt enable not stored");
    next_hold_a: assert property (!(wr && dci == 0) |=>
        next_on_q[0] == $past(next_on_q[0]))
        else $error("target state changed without a write");
    mod_layout_a: assert property (mstat_read_s |=>
        prdata[31:18] == 14'h0000 && prdata[15:13] == 3'h0 &&
        prdata[7:6] == 2'h0)
        else $error("module status reserved bits not zero");
    // go pulse lands one cycle after the write, the state one more
    go_trans_a: assert property ((go_dom0_s and
        (mst_q[0] < MST_TRANS && mst_q[0] != {3'b000, mnext_q[0]})) |->
        ##2 mst_q[0] >= MST_TRANS
        ##[1:40] mst_q[0] == $past(mst_q[0], 1) - MST_TRANS)
        else $error("module transition did not complete");
    mod_code_a: assert property (mst_q[0] == MST_ENABLE |=>
        module_clock_on[0] && module_reset_n[0])
        else $error("enable state without clock and reset release");
    irq_gate_a: assert property (emu_domain_irq[0] |->
        dom_emu_q[0] && dom_ie_q[0])
        else $error("interrupt without flag and enable");
endmodule

// ### verif/power_domain_status_control_bench.sv
// self-checking bench for the domain status and control block over apb
`timescale 1ns/1ps
module power_domain_status_control_bench;
    import pdsc_pkg::*;

    typedef struct {
        logic [11:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] exp_rd;
        logic exp_err;
    } pdsc_row_s;

    logic pclk;
    logic presetn;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] emu_domain_evt;
    logic [3:0] emu_module_evt;
    logic [3:0] emu_mod_reset_evt;
    logic [1:0] emu_domain_irq;
    logic [1:0] domain_power_on;
    logic [1:0] domain_por_n;
    logic [3:0] module_clock_on;
    logic [3:0] module_reset_n;
    logic [3:0] local_reset_n;
    logic [31:0] rd_q;
    logic err_q;
    int num_errors;
    int samples_checked;
    int cycles;
    pdsc_row_s rows [9];

    pdsc_top dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .emu_domain_evt(emu_domain_evt), .emu_module_evt(emu_module_evt),
        .emu_mod_reset_evt(emu_mod_reset_evt),
        .emu_domain_irq(emu_domain_irq), .domain_power_on(domain_power_on),
        .domain_por_n(domain_por_n), .module_clock_on(module_clock_on),
        .module_reset_n(module_reset_n), .local_reset_n(local_reset_n)
    );

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the global cycle ceiling ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] mask,
                          input logic [31:0] exp, input string what);
        apb(a, 1'b0, 32'h0);
        chk(rd_q & mask, exp, what);
    endtask

    initial begin
        presetn = 1'b0;
        paddr = 12'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        emu_domain_evt = 2'h0;
        emu_module_evt = 4'h0;
        emu_mod_reset_evt = 4'h0;
        num_errors = 0;
        samples_checked = 0;
        // plain register cases: address, write, data, read back, error
        rows[0] = '{12'h200, 1'b0, 32'h0, 32'h0000_0301, 1'b0};
        rows[1] = '{12'h204, 1'b0, 32'h0, 32'h0000_0000, 1'b0};
        rows[2] = '{12'h304, 1'b0, 32'h0, 32'h0000_0000, 1'b0};
        rows[3] = '{12'h7FC, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b1};
        rows[4] = '{12'h7FC, 1'b0, 32'h0, 32'h0000_0000, 1'b1};
        rows[5] = '{12'h304, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0};
        rows[6] = '{12'h304, 1'b0, 32'h0, 32'h0000_0301, 1'b0};
        rows[7] = '{12'h304, 1'b1, 32'h0, 32'h0, 1'b0};
        rows[8] = '{12'h128, 1'b0, 32'h0, 32'h0000_0000, 1'b0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].addr, rows[i].wr, rows[i].wdata);
            if (!rows[i].wr) begin
                chk(rd_q, rows[i].exp_rd, "table read");
            end
            chk({31'h0, err_q}, {31'h0, rows[i].exp_err}, "table err");
        end
        // emulation event with the enable off: flag only, no interrupt; then the enable raises it and clearing masks it
        @(posedge pclk);
        emu_domain_evt <= 2'b11;
        @(posedge pclk);
        emu_domain_evt <= 2'b00;
        rd_chk(12'h204, 32'h0000_0800, 32'h0000_0800, "emu flag");
        chk({30'h0, emu_domain_irq}, 32'h0, "irq while disabled");
        apb(12'h304, 1'b1, 32'h0000_0200);
        @(posedge pclk);
        chk({30'h0, emu_domain_irq}, 32'h2, "irq enabled");
        apb(12'h304, 1'b1, 32'h0000_0000);
        @(posedge pclk);
        chk({30'h0, emu_domain_irq}, 32'h0, "irq masked");
        // power up domain 1 and enable module 1 with one go
        apb(12'h304, 1'b1, 32'h0000_0101);
        apb(12'hA04, 1'b1, 32'h0000_0103);
        apb(12'h120, 1'b1, 32'h0000_0002);
        rd_chk(12'h128, 32'h0000_0003, 32'h0000_0002, "go status");
        apb(12'h804, 1'b0, 32'h0);
        chk({31'h0, rd_q[5:0] >= 6'h04}, 32'h1, "mid move");
        rd_chk(12'h204, 32'h0000_031F, 32'h0000_0001, "por held");
        chk({30'h0, domain_power_on}, 32'h3, "domain on");
        chk({30'h0, domain_por_n}, 32'h1, "por low");
        repeat (60) @(posedge pclk);
        rd_chk(12'h204, 32'hFFFF_FFFF, 32'h0000_0301, "domain up");
        rd_chk(12'h804, 32'hFFFF_FFFF, 32'h0000_1F03, "module on");
        rd_chk(12'h128, 32'hFFFF_FFFF, 32'h0, "go done");
        chk({28'h0, module_clock_on}, 32'h2, "module clock");
        chk({28'h0, module_reset_n & local_reset_n}, 32'h2, "mod rst");
        chk({30'h0, domain_por_n}, 32'h3, "por released");
        // power domain 1 down again
        apb(12'h304, 1'b1, 32'h0000_0100);
        apb(12'h120, 1'b1, 32'h0000_0002);
        repeat (40) @(posedge pclk);
        rd_chk(12'h204, 32'h0000_001F, 32'h0000_0000, "domain off");
        chk({30'h0, domain_power_on}, 32'h1, "power off");
        // module 0 of the boot-on domain; the go also clears its flag
        apb(12'hA00, 1'b1, 32'h0000_0103);
        apb(12'h120, 1'b1, 32'h0000_0001);
        repeat (20) @(posedge pclk);
        rd_chk(12'h800, 32'hFFFF_FFFF, 32'h0000_1F03, "mod0 on");
        rd_chk(12'h200, 32'hFFFF_FFFF, 32'h0000_0301, "emu clear");
        // power up without power good: the domain waits for software
        apb(12'h304, 1'b1, 32'h0000_0001);
        apb(12'h120, 1'b1, 32'h0000_0002);
        repeat (10) @(posedge pclk);
        rd_chk(12'h204, 32'h0000_031F, 32'h0000_0000, "wait pgood");
        apb(12'h304, 1'b1, 32'h0000_0101);
        repeat (40) @(posedge pclk);
        rd_chk(12'h204, 32'hFFFF_FFFF, 32'h0000_0301, "pgood up");
        // module emulation flags
        @(posedge pclk);
        emu_module_evt <= 4'h4;
        emu_mod_reset_evt <= 4'h8;
        @(posedge pclk);
        emu_module_evt <= 4'h0;
        emu_mod_reset_evt <= 4'h0;
        rd_chk(12'h808, 32'hFFFF_0000, 32'h0002_0000, "mod emu");
        rd_chk(12'h80C, 32'hFFFF_0000, 32'h0001_0000, "mod emu rst");
        // reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({30'h0, domain_power_on}, 32'h0, "outs in reset");
        chk({28'h0, module_clock_on}, 32'h0, "clocks in reset");
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(12'h204, 32'hFFFF_FFFF, 32'h0, "after reset");
        rd_chk(12'h200, 32'hFFFF_FFFF, 32'h0000_0301, "boot on");
        tally_and_finish();
    end
endmodule
